// ---- design/spn_sci.sv ----
// Operation
// - frame is start, 8/7+parity or 9/8+parity data, one stop bit
// - parity over low 7 or 8 bits; even or odd by odd select
// - with parity on, transmitted word msb is replaced by parity
// - receiver checks parity, sets parity error, interrupt under its enable
// - address mark wake-up looks at data msb, not parity bit
// - sixteen samples per bit, value is majority of samples 8 to 10
// - unequal samples 8 to 10 on a data bit set noise, majority kept
// - sampling phase resynchronised on each start bit; remote keeps deviation low
// - line sampled once per sampling tick, up to one tick of offset
// - start edge is a one then a zero; fewer than three ones before, or a one at samples 3, 5 or 7, sets noise
// - any one at start samples 8, 9 or 10 sets noise
// - wait has no effect; halt stops line activity and freezes registers but the pin synchroniser and read data
// - all events share one interrupt, gated by enables and global mask
// - overrun when word completes with receive full; holding kept
// - buffer empty set on load; no load until cleared by status then write
// - transmit done set only after data frame; cleared by status then write
// - receive full set when data readable; cleared by status then read
// - idle flag set on idle line, rearmed only by a new receive full
// - noise set with receive full, no own interrupt, cleared by sequence
// - framing error on bad stop or break; overrun alone if both
// - status reads c0 after reset
// - parity setting changes apply from the next frame
`timescale 1ns/1ps
`default_nettype none
`include "spn_consts.svh"
module spn_sci (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // serial line
  input wire logic rx_i,
  output logic tx_o,
  // system
  input wire logic halt_i,
  input wire logic irq_mask_i,
  output logic irq_o
);
  logic run;
  logic [7:0] baud;
  logic [7:0] div_cnt;
  logic s_tick;
  logic [2:0] pin_s;
  logic rx_lvl;
  logic [6:0] c1;
  logic [7:0] c2;
  logic [7:0] tx_hold;
  logic [7:0] rx_hold;
  logic r8;
  localparam logic [7:0] st_reset = `SPN_RST_STATUS;
  logic tx_empty, tx_done, rx_full, idle_f, ovr, noise, frame_err, par_err;
  logic seen;
  logic st_acc, dr_rd, dr_wr, clr_rx, clr_tx;
  spn_pkg::spn_rx_state_type rx_st;
  logic [4:0] s_cnt;
  logic [2:0] hist;
  logic [2:0] vote;
  logic [2:0] v3;
  logic [3:0] idx;
  logic [8:0] sh;
  logic nacc;
  logic m_l, par_on_l, par_odd_l;
  logic rx_done, stop_ok, par_bad, msb, accept;
  logic [7:0] icnt;
  logic idle_arm, idle_evt;
  spn_pkg::spn_tx_state_type tx_st;
  logic [3:0] t_sc;
  logic [3:0] t_cnt;
  logic [3:0] t_n;
  logic [10:0] t_sh;
  logic [8:0] tx_word;
  logic [8:0] next_word;
  logic t_bt, t_load, tc_set;
  logic [7:0] status;

  function automatic logic maj(input logic [2:0] v);
    maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj

  // halt freezes every register but the pin synchroniser and read data; wait mode needs nothing here
  assign run = !halt_i;
  assign st_acc = run && (rd_i || wr_i) && addr_i == `SPN_ADDR_STATUS;
  assign dr_rd = run && rd_i && addr_i == `SPN_ADDR_DATA;
  assign dr_wr = run && wr_i && addr_i == `SPN_ADDR_DATA;
  assign clr_rx = dr_rd && seen;
  assign clr_tx = dr_wr && seen;
  assign status = {tx_empty, tx_done, rx_full, idle_f, ovr, noise, frame_err, par_err};

  // sampling tick, sixteen per bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 8'h00;
    end else if (run) begin
      div_cnt <= (div_cnt >= baud) ? 8'h00 : div_cnt + 8'h01;
    end
  end
  assign s_tick = run && div_cnt >= baud;

  // pin synchroniser; level moves once the last two stages agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s <= 3'h7;
      rx_lvl <= 1'b1;
    end else begin
      pin_s <= {pin_s[1:0], rx_i};
      if (pin_s[1] == pin_s[2]) begin
        rx_lvl <= pin_s[2];
      end
    end
  end

  // status access arms the clearing sequence
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen <= 1'b0;
    end else if (st_acc) begin
      seen <= 1'b1;
    end else if (dr_rd || dr_wr) begin
      seen <= 1'b0;
    end
  end

  // control, baud and transmit holding registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1 <= 7'(`SPN_RST_CTRL);
      c2 <= `SPN_RST_CTRL;
      baud <= `SPN_RST_BAUD;
      tx_hold <= 8'h00;
    end else if (run) begin
      if (wr_i && addr_i == `SPN_ADDR_CTRL1) begin
        c1 <= wdata_i[6:0];
      end
      if (wr_i && addr_i == `SPN_ADDR_CTRL2) begin
        c2 <= wdata_i;
      end
      if (wr_i && addr_i == `SPN_ADDR_BAUD) begin
        baud <= wdata_i;
      end
      if (dr_wr) begin
        tx_hold <= wdata_i;
      end
      // hardware wake-up from mute
      if (c2[`SPN_C2_RWU] && ((rx_done && accept) || (idle_evt && !c1[`SPN_C1_WAKE]))) begin
        c2[`SPN_C2_RWU] <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SPN_ADDR_STATUS: rdata_o <= status;
        `SPN_ADDR_DATA: rdata_o <= rx_hold;
        `SPN_ADDR_CTRL1: rdata_o <= {r8, c1};
        `SPN_ADDR_CTRL2: rdata_o <= c2;
        `SPN_ADDR_BAUD: rdata_o <= baud;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // receiver frame decode
  assign v3 = {vote[1:0], rx_lvl};
  assign rx_done = s_tick && c2[`SPN_C2_RE] && rx_st == spn_pkg::RX_STOP && s_cnt == `SPN_S_V3;
  assign stop_ok = maj(v3);
  assign par_bad = par_on_l && ((m_l ? ^sh[8:0] : ^sh[7:0]) != par_odd_l);
  assign msb = m_l ? (par_on_l ? sh[7] : sh[8]) : (par_on_l ? sh[6] : sh[7]);
  assign accept = !c2[`SPN_C2_RWU] || (c1[`SPN_C1_WAKE] && msb);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st <= spn_pkg::RX_IDLE;
      s_cnt <= 5'h00;
      hist <= 3'h7;
      vote <= 3'h0;
      idx <= 4'h0;
      sh <= 9'h000;
      nacc <= 1'b0;
      m_l <= 1'b0;
      par_on_l <= 1'b0;
      par_odd_l <= 1'b0;
    end else if (s_tick) begin
      hist <= {hist[1:0], rx_lvl};
      case (rx_st)
        spn_pkg::RX_IDLE: begin
          if (hist[0] && !rx_lvl) begin
            rx_st <= spn_pkg::RX_START;
            s_cnt <= `SPN_S_FIRST;
            sh <= 9'h000;
            m_l <= c1[`SPN_C1_M];
            par_on_l <= c1[`SPN_C1_PAR_ON];
            par_odd_l <= c1[`SPN_C1_PAR_ODD];
            if (hist != 3'h7) begin
              nacc <= 1'b1;
            end
          end
        end
        spn_pkg::RX_START: begin
          s_cnt <= s_cnt + 5'h01;
          if (rx_lvl && (s_cnt == `SPN_S_E1 || s_cnt == `SPN_S_E2 || s_cnt == `SPN_S_E3)) begin
            nacc <= 1'b1;
          end
          if (s_cnt >= `SPN_S_V1 && s_cnt <= `SPN_S_V3) begin
            vote <= v3;
            if (rx_lvl) begin
              nacc <= 1'b1;
            end
          end
          if (s_cnt == `SPN_S_LAST) begin
            s_cnt <= `SPN_S_FIRST;
            idx <= 4'h0;
            // false start drops the frame; noise stays pending
            rx_st <= maj(vote) ? spn_pkg::RX_IDLE : spn_pkg::RX_DATA;
          end
        end
        spn_pkg::RX_DATA: begin
          s_cnt <= s_cnt + 5'h01;
          if (s_cnt >= `SPN_S_V1 && s_cnt <= `SPN_S_V3) begin
            vote <= v3;
          end
          if (s_cnt == `SPN_S_LAST) begin
            s_cnt <= `SPN_S_FIRST;
            sh[idx] <= maj(vote);
            if (!(&vote) && (|vote)) begin
              nacc <= 1'b1;
            end
            if (idx == (m_l ? 4'h8 : 4'h7)) begin
              rx_st <= spn_pkg::RX_STOP;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        spn_pkg::RX_STOP: begin
          s_cnt <= s_cnt + 5'h01;
          vote <= v3;
          if (s_cnt == `SPN_S_V3) begin
            rx_st <= spn_pkg::RX_IDLE;
            nacc <= 1'b0;
          end
        end
        default: rx_st <= spn_pkg::RX_IDLE;
      endcase
      if (!c2[`SPN_C2_RE]) begin
        rx_st <= spn_pkg::RX_IDLE;
      end
    end
  end

  // idle line detection
  assign idle_evt = s_tick && c2[`SPN_C2_RE] && rx_st == spn_pkg::RX_IDLE && rx_lvl &&
                    icnt == (c1[`SPN_C1_M] ? `SPN_IDLE_W9 : `SPN_IDLE_W8) - 8'h01;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      icnt <= 8'h00;
    end else if (s_tick) begin
      if (rx_st != spn_pkg::RX_IDLE || !rx_lvl) begin
        icnt <= 8'h00;
      end else if (icnt != 8'hff) begin
        icnt <= icnt + 8'h01;
      end
    end
  end

  // receive flags; a hardware set wins over the clearing read
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_full <= st_reset[`SPN_ST_RX_FULL];
      idle_f <= 1'b0;
      ovr <= 1'b0;
      noise <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      idle_arm <= 1'b0;
      rx_hold <= 8'h00;
      r8 <= 1'b0;
    end else begin
      if (rx_done && accept && rx_full) begin
        ovr <= 1'b1;
      end else if (clr_rx) begin
        ovr <= 1'b0;
      end
      if (rx_done && accept && !rx_full) begin
        rx_hold <= sh[7:0];
        r8 <= sh[8];
        rx_full <= 1'b1;
        noise <= nacc;
        frame_err <= !stop_ok;
        par_err <= par_bad;
        idle_arm <= 1'b1;
      end else if (clr_rx) begin
        rx_full <= 1'b0;
        noise <= 1'b0;
        frame_err <= 1'b0;
        par_err <= 1'b0;
      end
      if (idle_evt && idle_arm && !c2[`SPN_C2_RWU]) begin
        idle_f <= 1'b1;
        idle_arm <= 1'b0;
      end else if (clr_rx) begin
        idle_f <= 1'b0;
      end
    end
  end

  // transmitter
  always_comb begin
    next_word = {c1[`SPN_C1_T8], tx_hold};
    if (c1[`SPN_C1_PAR_ON]) begin
      if (c1[`SPN_C1_M]) begin
        next_word[8] = ^tx_hold ^ c1[`SPN_C1_PAR_ODD];
      end else begin
        next_word[7] = ^tx_hold[6:0] ^ c1[`SPN_C1_PAR_ODD];
      end
    end
  end
  assign t_load = run && c2[`SPN_C2_TE] && tx_st == spn_pkg::TX_IDLE && !tx_empty;
  assign t_bt = s_tick && t_sc == `SPN_TX_LAST;
  assign tc_set = tx_st == spn_pkg::TX_RUN && t_bt && t_cnt == t_n - 4'h1;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st <= spn_pkg::TX_IDLE;
      t_sc <= 4'h0;
      t_cnt <= 4'h0;
      t_n <= 4'h0;
      t_sh <= 11'h7ff;
      tx_word <= 9'h000;
      tx_o <= 1'b1;
    end else if (t_load) begin
      tx_st <= spn_pkg::TX_RUN;
      t_sc <= 4'h0;
      t_cnt <= 4'h0;
      t_n <= c1[`SPN_C1_M] ? 4'hb : 4'ha;
      tx_word <= next_word;
      t_sh <= c1[`SPN_C1_M] ? {1'b1, next_word, 1'b0} : {2'h3, next_word[7:0], 1'b0};
      tx_o <= 1'b0;
    end else if (s_tick && tx_st == spn_pkg::TX_RUN) begin
      t_sc <= t_sc + 4'h1;
      if (tc_set) begin
        tx_st <= spn_pkg::TX_IDLE;
        tx_o <= 1'b1;
      end else if (t_bt) begin
        t_sh <= {1'b1, t_sh[10:1]};
        tx_o <= t_sh[1];
        t_cnt <= t_cnt + 4'h1;
      end
    end
  end

  // transmit flags
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_empty <= st_reset[`SPN_ST_TX_EMPTY];
      tx_done <= st_reset[`SPN_ST_TX_DONE];
    end else begin
      if (t_load) begin
        tx_empty <= 1'b1;
      end else if (clr_tx) begin
        tx_empty <= 1'b0;
      end
      if (tc_set) begin
        tx_done <= 1'b1;
      end else if (clr_tx) begin
        tx_done <= 1'b0;
      end
    end
  end

  // shared interrupt line, frozen in halt
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (run) begin
      irq_o <= !irq_mask_i && ((c2[`SPN_C2_EMPTY_IRQ] && tx_empty) || (c2[`SPN_C2_DONE_IRQ] && tx_done) ||
               (c2[`SPN_C2_RX_IRQ] && (rx_full || ovr)) || (c2[`SPN_C2_QUIET_IRQ] && idle_f) ||
               (c1[`SPN_C1_PAR_IRQ] && par_err));
    end
  end

  a_overrun_keeps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_done && accept && rx_full |=> ovr && $stable(rx_hold))
    else $error("overrun changed holding data");
  a_full_sets: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_done && accept && !rx_full |=> rx_full && rx_hold == $past(sh[7:0]))
    else $error("receive full not set");
  a_frame_with_overrun: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_done && accept && rx_full && !clr_rx |=> frame_err == $past(frame_err))
    else $error("framing error set with overrun");
  a_empty_on_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    t_load |=> tx_empty && !t_load && tx_o == 1'b0)
    else $error("buffer empty not set on load");
  a_halt_freeze: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    halt_i |=> $stable(status) && $stable(tx_o) && $stable(irq_o))
    else $error("state moved in halt");
  a_irq_masked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_mask_i && !halt_i |=> !irq_o)
    else $error("interrupt despite global mask");
  a_full_irq: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_full && c2[`SPN_C2_RX_IRQ] && !irq_mask_i && !halt_i |=> irq_o)
    else $error("receive interrupt missing");
  a_noise_vote: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_tick && rx_st == spn_pkg::RX_DATA && s_cnt == `SPN_S_LAST && (|vote) && !(&vote) |=> nacc)
    else $error("noise not recorded");
  a_tx_parity: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    t_load && c1[`SPN_C1_PAR_ON] && !c1[`SPN_C1_M] |=> (^tx_word[7:0]) == $past(c1[`SPN_C1_PAR_ODD]))
    else $error("transmit parity wrong");
endmodule : spn_sci
`default_nettype wire

// ---- include/spn_consts.svh ----
`ifndef SPN_CONSTS_SVH
`define SPN_CONSTS_SVH
// register indices on the register port
`define SPN_ADDR_STATUS 3'h0
`define SPN_ADDR_DATA 3'h1
`define SPN_ADDR_CTRL1 3'h2
`define SPN_ADDR_CTRL2 3'h3
`define SPN_ADDR_BAUD 3'h4
// reset values
`define SPN_RST_STATUS 8'hc0
`define SPN_RST_CTRL 8'h00
`define SPN_RST_BAUD 8'h00
// status bit positions
`define SPN_ST_PAR_ERR 0
`define SPN_ST_FRAME_ERR 1
`define SPN_ST_NOISE 2
`define SPN_ST_OR 3
`define SPN_ST_IDLE 4
`define SPN_ST_RX_FULL 5
`define SPN_ST_TX_DONE 6
`define SPN_ST_TX_EMPTY 7
// first control register bit positions
`define SPN_C1_PAR_IRQ 0
`define SPN_C1_PAR_ODD 1
`define SPN_C1_PAR_ON 2
`define SPN_C1_WAKE 3
`define SPN_C1_M 4
`define SPN_C1_T8 6
// second control register bit positions
`define SPN_C2_RWU 1
`define SPN_C2_RE 2
`define SPN_C2_TE 3
`define SPN_C2_QUIET_IRQ 4
`define SPN_C2_RX_IRQ 5
`define SPN_C2_DONE_IRQ 6
`define SPN_C2_EMPTY_IRQ 7
// oversampling positions within one bit
`define SPN_S_FIRST 5'h01
`define SPN_S_E1 5'h03
`define SPN_S_E2 5'h05
`define SPN_S_E3 5'h07
`define SPN_S_V1 5'h08
`define SPN_S_V3 5'h0a
`define SPN_S_LAST 5'h10
`define SPN_TX_LAST 4'hf
// idle frame length in samples for 8 and 9 bit words
`define SPN_IDLE_W8 8'ha0
`define SPN_IDLE_W9 8'hb0
`endif

// ---- include/spn_pkg.sv ----
package spn_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spn_rx_state_type;
  typedef enum logic {TX_IDLE, TX_RUN} spn_tx_state_type;
endpackage : spn_pkg

// ---- tb/spn_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module spn_remote #(
  parameter int BIT_CLKS = 64
) (
  // clock
  input wire logic sys_clk_i,
  // serial line
  output logic line_o,
  input wire logic line_i
);
  initial line_o = 1'b1;

  // start, lsb first data, stop, then one idle bit so the next start edge is valid
  task automatic send(input logic [8:0] w, input int nb, input logic stop, input int gl);
    logic b_v;
    for (int b = -1; b <= nb + 1; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        b_v = (b < 0) ? 1'b0 : (b < nb) ? w[b] : (b == nb) ? stop : 1'b1;
        // a short flip that lands on exactly one of the middle samples
        if (b == gl && c >= 34 && c < 38) b_v = ~b_v;
        @(posedge sys_clk_i);
        line_o <= b_v;
      end
    end
  endtask : send

  // fr[0] start, fr[nb:1] data, fr[nb+1] stop, each taken mid bit
  task automatic capture(output logic [10:0] fr, input int nb);
    int n;
    n = 0;
    fr = '0;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
    for (int b = 0; b <= nb + 1; b++) begin
      fr[b] = line_i;
      repeat (BIT_CLKS) @(posedge sys_clk_i);
    end
  endtask : capture
endmodule : spn_remote
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spn_consts.svh"
module tb;
  logic sys_clk_i, rst_n_i, wr_i, rd_i, rx_i, tx_o, halt_i, irq_mask_i, irq_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v;
  logic [10:0] fr;
  int errors, tests_run, cyc;

  spn_sci dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .halt_i(halt_i), .irq_mask_i(irq_mask_i),
    .irq_o(irq_o));
  spn_remote rem_u (.sys_clk_i(sys_clk_i), .line_o(rx_i), .line_i(tx_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg

  // let any pending idle flag rise, then clear all receive flags
  task automatic settle();
    repeat (800) @(posedge sys_clk_i);
    rd_reg(`SPN_ADDR_STATUS, v);
    rd_reg(`SPN_ADDR_DATA, v);
  endtask : settle

  task automatic t_reset();
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, `SPN_RST_STATUS);
    rd_reg(3'h7, v);
    check(v, 8'h00);
    wr_reg(`SPN_ADDR_STATUS, 8'h3f);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, `SPN_RST_STATUS);
    wr_reg(`SPN_ADDR_BAUD, 8'h03);
    wr_reg(`SPN_ADDR_CTRL2, 8'h2c);
  endtask : t_reset

  task automatic t_rx_idle();
    wr_reg(`SPN_ADDR_CTRL1, 8'h00);
    rem_u.send(9'h0a5, 8, 1'b1, 99);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'he0);
    check(irq_o, 1'b1);
    irq_mask_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check(irq_o, 1'b0);
    irq_mask_i <= 1'b0;
    rd_reg(`SPN_ADDR_DATA, v);
    check(v, 8'ha5);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'hc0);
    repeat (800) @(posedge sys_clk_i);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'hd0);
    rd_reg(`SPN_ADDR_DATA, v);
    repeat (800) @(posedge sys_clk_i);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'hc0);
  endtask : t_rx_idle

  // bit 2 word length, bit 1 odd select, bit 0 corrupt the parity bit
  task automatic t_parity();
    logic [8:0] w;
    wr_reg(`SPN_ADDR_CTRL2, 8'h0c);
    for (int i = 0; i < 8; i++) begin
      w = i[2] ? {i[1] ^ i[0], 8'h35} : {1'b0, i[1] ^ i[0], 7'h35};
      settle();
      wr_reg(`SPN_ADDR_CTRL1, {3'b000, i[2], 1'b0, 1'b1, i[1], 1'b1});
      rem_u.send(w, i[2] ? 9 : 8, 1'b1, 99);
      check(irq_o, i[0]);
      rd_reg(`SPN_ADDR_STATUS, v);
      check(v, {7'h70, i[0]});
      rd_reg(`SPN_ADDR_DATA, v);
      check(v & (i[2] ? 8'hff : 8'h7f), 8'h35);
    end
  endtask : t_parity

  // glitch in the start bit, then in data bit 0
  task automatic t_noise();
    wr_reg(`SPN_ADDR_CTRL2, 8'h2c);
    wr_reg(`SPN_ADDR_CTRL1, 8'h00);
    for (int g = -1; g < 1; g++) begin
      settle();
      rem_u.send(9'h0a5, 8, 1'b1, g);
      rd_reg(`SPN_ADDR_STATUS, v);
      check(v, 8'he4);
      rd_reg(`SPN_ADDR_DATA, v);
      check(v, 8'ha5);
    end
  endtask : t_noise

  task automatic t_overrun();
    settle();
    rem_u.send(9'h0a5, 8, 1'b0, 99);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'he2);
    rd_reg(`SPN_ADDR_DATA, v);
    check(v, 8'ha5);
    settle();
    rem_u.send(9'h05a, 8, 1'b1, 99);
    rem_u.send(9'h03c, 8, 1'b0, 99);
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'he8);
    rd_reg(`SPN_ADDR_DATA, v);
    check(v, 8'h5a);
  endtask : t_overrun

  task automatic t_tx();
    for (int po = 0; po < 2; po++) begin
      settle();
      wr_reg(`SPN_ADDR_CTRL1, {6'h01, po[0], 1'b0});
      fork
        rem_u.capture(fr, 8);
        begin
          rd_reg(`SPN_ADDR_STATUS, v);
          wr_reg(`SPN_ADDR_DATA, 8'hb5);
          rd_reg(`SPN_ADDR_STATUS, v);
          check(v, 8'h80);
        end
      join
      rd_reg(`SPN_ADDR_STATUS, v);
      check(v, 8'hc0);
      check(fr, {2'b01, po[0], 7'h35, 1'b0});
    end
  endtask : t_tx

  // a frame sent while halted must leave no trace
  task automatic t_halt();
    settle();
    halt_i <= 1'b1;
    rem_u.send(9'h0a5, 8, 1'b1, 99);
    halt_i <= 1'b0;
    rd_reg(`SPN_ADDR_STATUS, v);
    check(v, 8'hc0);
  endtask : t_halt

  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    halt_i = 1'b0;
    irq_mask_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_rx_idle();
    t_parity();
    t_noise();
    t_overrun();
    t_tx();
    t_halt();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
